// ---- include/arts_pkg.sv ----
/*
  shared constants and carrier types for the split auto-reload timer.
  assumes an 8-bit special function register bus on the system clock.
*/
package arts_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ARTS_ADDR_CTRL = 8'hc8;
  localparam logic [7:0] ARTS_ADDR_RLD_LO = 8'hca;
  localparam logic [7:0] ARTS_ADDR_RLD_HI = 8'hcb;
  localparam logic [7:0] ARTS_ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0] ARTS_ADDR_CNT_HI = 8'hcd;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int ARTS_BIT_HI_FLAG = 7;
  localparam int ARTS_BIT_LO_FLAG = 6;
  localparam int ARTS_BIT_LO_IRQ_EN = 5;
  localparam int ARTS_BIT_SPLIT = 3;
  localparam int ARTS_BIT_RUN = 2;
  localparam int ARTS_BIT_ALT_CLK = 0;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] ARTS_RST_BYTE = 8'h00;
  localparam logic [7:0] ARTS_BYTE_MAX = 8'hff;
  localparam logic [3:0] ARTS_DIV12_LAST = 4'hb;
  localparam logic [2:0] ARTS_DIV8_LAST = 3'h7;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic
  {
    ARTS_MODE_16 = 1'b0,
    ARTS_MODE_SPLIT = 1'b1
  } arts_mode_e;

  typedef struct packed
  {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } arts_sfr_req_s;

  typedef struct packed
  {
    logic div12;
    logic ext8;
  } arts_tick_s;

  typedef struct packed
  {
    logic hi_flag;
    logic lo_flag;
    logic lo_irq_en;
    arts_mode_e mode;
    logic run;
    logic alt_clk;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] rdata;
    logic irq;
  } arts_state_s;

  typedef struct packed
  {
    logic [2:0] sync;
    logic level;
    logic [2:0] div8;
    logic [3:0] div12;
    arts_tick_s tick;
  } arts_tick_state_s;

endpackage

// ---- design/arts_tick_gen.sv ----
/*
  count clock ticks: system clock divided by 12, and the external
  oscillator pin divided by 8 after synchronisation.
  assumes the external oscillator is far slower than the system clock.
*/
`timescale 1ns/1ps

module arts_tick_gen
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // external oscillator pin
  input wire logic ext_osc_i,
  // one-cycle tick pulses
  output arts_pkg::arts_tick_s tick_o
);
  import arts_pkg::*;

  arts_tick_state_s st_ff;
  arts_tick_state_s nxt_st;
  logic rise;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    rise = 1'b0;
    nxt_st.sync = {st_ff.sync[1:0], ext_osc_i};
    // level changes only once stages two and three agree
    if (st_ff.sync[1] == st_ff.sync[2])
    begin
      nxt_st.level = st_ff.sync[2];
      rise = st_ff.sync[2] & ~st_ff.level;
    end
    nxt_st.tick.ext8 = 1'b0;
    if (rise)
    begin
      nxt_st.div8 = st_ff.div8 + 3'h1;
      nxt_st.tick.ext8 = (st_ff.div8 == ARTS_DIV8_LAST);
    end
    nxt_st.tick.div12 = (st_ff.div12 == ARTS_DIV12_LAST);
    if (st_ff.div12 == ARTS_DIV12_LAST)
    begin
      nxt_st.div12 = 4'h0;
    end
    else
    begin
      nxt_st.div12 = st_ff.div12 + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

// ---- design/arts_timer.sv ----
/*
  16-bit auto-reload timer that can split into two 8-bit auto-reload
  timers, with its control, reload and count registers on the sfr bus.
  assumes the interrupt enable and clock control bits come from
  registers elsewhere on the system clock.
*/
`timescale 1ns/1ps

// Overview of operation
// - split bit clear gives one 16-bit counter; set gives two 8-bit counters.
// - 16-bit wrap from ffff loads both reload bytes into the count.
// - each 16-bit wrap sets the high overflow flag.
// - with timer interrupt enabled, every 16-bit overflow requests an interrupt.
// - with low interrupt enable too, low byte wraps also request an interrupt.
// - low byte wrap sets the low overflow flag in either mode.
// - in split mode each byte reloads from its own reload byte.
// - run bit gates whole timer in 16-bit mode, only high byte when split.
// - alternate clock is system clock over 12, or external oscillator over 8.
// - a byte clock select of one picks the undivided system clock.
// - external oscillator over 8 is synchronised before it counts.
// - split high byte wrap sets high flag and requests an interrupt.
// - split with low enable, either byte interrupts; software reads both flags.
// - hardware never clears overflow flags; software writes them clear.
// - control bits 4 and 1 read zero and ignore writes.
// - low count register is low half, or the whole low byte when split.
// - high byte clock select acts only in split mode.
// - low byte clock select clocks whole timer, or low byte when split.
module arts_timer
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // sfr bus
  input arts_pkg::arts_sfr_req_s sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  // outside control bits
  input wire logic timer_irq_enable_i,
  input wire logic high_byte_clock_select_i,
  input wire logic low_byte_clock_select_i,
  // external oscillator pin
  input wire logic ext_osc_i,
  // interrupt request
  output logic timer_irq_o
);
  import arts_pkg::*;

  arts_state_s st_ff;
  arts_state_s nxt_st;
  arts_tick_s tick;

  logic alt_tick;
  logic lo_tick;
  logic hi_tick;
  logic split;
  logic lo_en;
  logic hi_en;
  logic lo_wrap;
  logic hi_wrap;
  logic wr_ctrl;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic [7:0] ctrl_view;
  logic [7:0] rd_mux;

  // ---------------------------------------------------------------
  // tick source
  // ---------------------------------------------------------------
  arts_tick_gen u_tick
  (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ext_osc_i(ext_osc_i),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------
  always_comb
  begin
    split = (st_ff.mode == ARTS_MODE_SPLIT);
    // alternate clock chosen by the control register
    if (st_ff.alt_clk)
    begin
      alt_tick = tick.ext8;
    end
    else
    begin
      alt_tick = tick.div12;
    end
    // low byte, or whole timer in 16-bit mode
    if (low_byte_clock_select_i)
    begin
      lo_tick = 1'b1;
    end
    else
    begin
      lo_tick = alt_tick;
    end
    // high byte select only matters when split
    if (!split)
    begin
      hi_tick = lo_tick;
    end
    else if (high_byte_clock_select_i)
    begin
      hi_tick = 1'b1;
    end
    else
    begin
      hi_tick = alt_tick;
    end
  end

  // ---------------------------------------------------------------
  // count enables and wraps
  // ---------------------------------------------------------------
  always_comb
  begin
    if (split)
    begin
      lo_en = lo_tick;
      hi_en = st_ff.run & hi_tick;
    end
    else
    begin
      lo_en = st_ff.run & lo_tick;
      hi_en = 1'b0;
    end
    lo_wrap = lo_en & (st_ff.cnt_lo == ARTS_BYTE_MAX);
    if (split)
    begin
      hi_wrap = hi_en & (st_ff.cnt_hi == ARTS_BYTE_MAX);
    end
    else
    begin
      hi_wrap = lo_wrap & (st_ff.cnt_hi == ARTS_BYTE_MAX);
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  always_comb
  begin
    wr_ctrl = sfr_req_i.wr & (sfr_req_i.addr == ARTS_ADDR_CTRL);
    wr_rld_lo = sfr_req_i.wr & (sfr_req_i.addr == ARTS_ADDR_RLD_LO);
    wr_rld_hi = sfr_req_i.wr & (sfr_req_i.addr == ARTS_ADDR_RLD_HI);
    wr_cnt_lo = sfr_req_i.wr & (sfr_req_i.addr == ARTS_ADDR_CNT_LO);
    wr_cnt_hi = sfr_req_i.wr & (sfr_req_i.addr == ARTS_ADDR_CNT_HI);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;

    // control register; bits 4 and 1 are not stored
    if (wr_ctrl)
    begin
      nxt_st.hi_flag = sfr_req_i.wdata[ARTS_BIT_HI_FLAG];
      nxt_st.lo_flag = sfr_req_i.wdata[ARTS_BIT_LO_FLAG];
      nxt_st.lo_irq_en = sfr_req_i.wdata[ARTS_BIT_LO_IRQ_EN];
      nxt_st.mode = arts_mode_e'(sfr_req_i.wdata[ARTS_BIT_SPLIT]);
      nxt_st.run = sfr_req_i.wdata[ARTS_BIT_RUN];
      nxt_st.alt_clk = sfr_req_i.wdata[ARTS_BIT_ALT_CLK];
    end

    // reload registers
    if (wr_rld_lo)
    begin
      nxt_st.rld_lo = sfr_req_i.wdata;
    end
    if (wr_rld_hi)
    begin
      nxt_st.rld_hi = sfr_req_i.wdata;
    end

    // low byte counting
    if (lo_wrap)
    begin
      nxt_st.cnt_lo = st_ff.rld_lo;
    end
    else if (lo_en)
    begin
      nxt_st.cnt_lo = st_ff.cnt_lo + 8'h01;
    end

    // high byte counting
    if (split)
    begin
      if (hi_wrap)
      begin
        nxt_st.cnt_hi = st_ff.rld_hi;
      end
      else if (hi_en)
      begin
        nxt_st.cnt_hi = st_ff.cnt_hi + 8'h01;
      end
    end
    else
    begin
      if (hi_wrap)
      begin
        nxt_st.cnt_hi = st_ff.rld_hi;
      end
      else if (lo_wrap)
      begin
        nxt_st.cnt_hi = st_ff.cnt_hi + 8'h01;
      end
    end

    // software count writes win over counting
    if (wr_cnt_lo)
    begin
      nxt_st.cnt_lo = sfr_req_i.wdata;
    end
    if (wr_cnt_hi)
    begin
      nxt_st.cnt_hi = sfr_req_i.wdata;
    end

    // overflow flags: a set beats a clear in the same cycle
    if (hi_wrap)
    begin
      nxt_st.hi_flag = 1'b1;
    end
    if (lo_wrap)
    begin
      nxt_st.lo_flag = 1'b1;
    end

    // interrupt request level
    nxt_st.irq = timer_irq_enable_i
                 & (st_ff.hi_flag | (st_ff.lo_irq_en & st_ff.lo_flag));

    // read data
    nxt_st.rdata = rd_mux;
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_view = ARTS_RST_BYTE;
    ctrl_view[ARTS_BIT_HI_FLAG] = st_ff.hi_flag;
    ctrl_view[ARTS_BIT_LO_FLAG] = st_ff.lo_flag;
    ctrl_view[ARTS_BIT_LO_IRQ_EN] = st_ff.lo_irq_en;
    ctrl_view[ARTS_BIT_SPLIT] = st_ff.mode;
    ctrl_view[ARTS_BIT_RUN] = st_ff.run;
    ctrl_view[ARTS_BIT_ALT_CLK] = st_ff.alt_clk;
    unique case (sfr_req_i.addr)
      ARTS_ADDR_CTRL:
      begin
        rd_mux = ctrl_view;
      end
      ARTS_ADDR_RLD_LO:
      begin
        rd_mux = st_ff.rld_lo;
      end
      ARTS_ADDR_RLD_HI:
      begin
        rd_mux = st_ff.rld_hi;
      end
      ARTS_ADDR_CNT_LO:
      begin
        rd_mux = st_ff.cnt_lo;
      end
      ARTS_ADDR_CNT_HI:
      begin
        rd_mux = st_ff.cnt_hi;
      end
      default:
      begin
        rd_mux = ARTS_RST_BYTE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sfr_rdata_o = st_ff.rdata;
  assign timer_irq_o = st_ff.irq;

endmodule

// ---- test/arts_timer_checker.sv ----
/*
  port assertions for the split auto-reload timer.
  assumes it is bound to arts_timer on the system clock.
*/
`timescale 1ns/1ps

module arts_timer_checker
(
  // clock and reset
  input logic mclk_i,
  input logic reset_n_i,
  // sfr bus
  input arts_pkg::arts_sfr_req_s sfr_req_i,
  input logic [7:0] sfr_rdata_o,
  // outside control bits
  input logic timer_irq_enable_i,
  input logic high_byte_clock_select_i,
  input logic low_byte_clock_select_i,
  // oscillator and interrupt
  input logic ext_osc_i,
  input logic timer_irq_o
);
  import arts_pkg::*;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire logic ctrl_wr = sfr_req_i.wr && (sfr_req_i.addr == ARTS_ADDR_CTRL);
  wire logic is_rld = sfr_req_i.addr inside {ARTS_ADDR_RLD_LO, ARTS_ADDR_RLD_HI};
  wire logic mapped = is_rld || sfr_req_i.addr inside {ARTS_ADDR_CTRL, ARTS_ADDR_CNT_LO, ARTS_ADDR_CNT_HI};
  default clocking chk_cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  unmapped_reads_zero_a: assert property (!mapped |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  unused_bits_zero_a: assert property (sfr_req_i.addr == ARTS_ADDR_CTRL |=> !sfr_rdata_o[4] && !sfr_rdata_o[1])
    else $error("unused control bit not zero");
  reload_readback_a: assert property (sfr_req_i.wr && is_rld ##1 !sfr_req_i.wr && $stable(sfr_req_i.addr)
    |=> sfr_rdata_o == $past(sfr_req_i.wdata, 2)) else $error("reload byte not written");
  ctrl_readback_a: assert property (ctrl_wr ##1 !sfr_req_i.wr && sfr_req_i.addr == ARTS_ADDR_CTRL
    |=> (sfr_rdata_o & 8'h2d) == ($past(sfr_req_i.wdata, 2) & 8'h2d)) else $error("control bits not written");
  irq_needs_enable_a: assert property (!timer_irq_enable_i |=> !timer_irq_o)
    else $error("irq without enable");
  irq_held_a: assert property (timer_irq_o && timer_irq_enable_i && !ctrl_wr && !$past(ctrl_wr) |=> timer_irq_o)
    else $error("irq dropped without clear");
  irq_shows_flag_a: assert property (timer_irq_o && $past(sfr_req_i.addr) == ARTS_ADDR_CTRL && !$past(ctrl_wr)
    |-> sfr_rdata_o[7] || sfr_rdata_o[6]) else $error("irq with no flag");
  irq_fall_cause_a: assert property ($fell(timer_irq_o)
    |-> !$past(timer_irq_enable_i) || $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("irq fell by itself");
endmodule

bind arts_timer arts_timer_checker u_chk
(
  .mclk_i,
  .reset_n_i,
  .sfr_req_i,
  .sfr_rdata_o,
  .timer_irq_enable_i,
  .high_byte_clock_select_i,
  .low_byte_clock_select_i,
  .ext_osc_i,
  .timer_irq_o
);

// ---- test/arts_timer_test.sv ----
/*
  self-checking bench for the split auto-reload timer.
  assumes the checker is bound and the oscillator pin runs free.
*/
`timescale 1ns/1ps

module arts_timer_test;
  import arts_pkg::*;
  // ---------------------------------------------------------------
  // signals and model
  // ---------------------------------------------------------------
  localparam logic [7:0] CT = ARTS_ADDR_CTRL;
  localparam logic [7:0] RL = ARTS_ADDR_RLD_LO;
  localparam logic [7:0] RH = ARTS_ADDR_RLD_HI;
  localparam logic [7:0] CL = ARTS_ADDR_CNT_LO;
  localparam logic [7:0] CH = ARTS_ADDR_CNT_HI;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  arts_sfr_req_s sfr_req_i = '0;
  logic [7:0] sfr_rdata_o;
  logic timer_irq_enable_i = 1'b0;
  logic high_byte_clock_select_i = 1'b0;
  logic low_byte_clock_select_i = 1'b1;
  logic ext_osc_i = 1'b0;
  logic timer_irq_o;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'ha469;
  int g;
  int i;
  int gap_q[$] = '{1, 12, 64};
  int m;
  logic [7:0] d;
  logic [7:0] rv;
  logic [7:0] addrs [7] = '{CT, RL, RH, CL, CH, 8'hc9, 8'hce};

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  initial
  begin
    #1.3;
    forever #20 ext_osc_i = ~ext_osc_i;
  end

  arts_timer DUT
  (
    .mclk_i,
    .reset_n_i,
    .sfr_req_i,
    .sfr_rdata_o,
    .timer_irq_enable_i,
    .high_byte_clock_select_i,
    .low_byte_clock_select_i,
    .ext_osc_i,
    .timer_irq_o
  );
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_i);
    sfr_req_i = '{1'b1, a, v};
    @(negedge mclk_i);
    sfr_req_i.wr = 1'b0;
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    sfr_req_i.addr = a;
    repeat (2) @(negedge mclk_i);
    chk(n, e, sfr_rdata_o);
  endtask

  task automatic wirq(input logic v);
    for (int k = 0; k < 300 && timer_irq_o !== v; k++)
      @(negedge mclk_i);
    chk("irq", {7'h0, v}, {7'h0, timer_irq_o});
  endtask

  // model: one tick of a w-bit auto-reload counter
  function automatic int mdl_step(input int c, input int rld, input int w);
    return (c == (1 << w) - 1) ? rld : c + 1;
  endfunction

  task automatic gap(input logic [7:0] a, output int r);
    logic [7:0] last;
    int t;
    int n;
    @(negedge mclk_i);
    sfr_req_i.addr = a;
    repeat (2) @(negedge mclk_i);
    last = sfr_rdata_o;
    t = 0;
    n = 0;
    for (int c = 0; c < 500 && n < 3; c++)
    begin
      @(negedge mclk_i);
      if (sfr_rdata_o !== last)
      begin
        n++;
        t = (n == 2) ? c : c - t;
      end
      last = sfr_rdata_o;
    end
    r = (n == 3) ? t : 0;
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge mclk_i);
    reset_n_i = 1'b1;
    foreach (addrs[k])
      rc("reset", addrs[k], 8'h00);
    for (i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      wr(RL, d);
      rc("reload_low", RL, d);
      wr(RH, ~d);
      rc("reload_high", RH, ~d);
      wr(CT, d & 8'hc3);
      rc("control", CT, d & 8'hc1);
    end
    wr(CT, 8'h12);
    rc("control", CT, 8'h00);
    wr(RL, 8'h00);
    wr(RH, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      low_byte_clock_select_i = (i == 0);
      wr(CT, (i == 2) ? 8'h05 : 8'h04);
      gap(CL, g);
      chk("tick_gap", 8'(gap_q[i]), 8'(g));
    end
    low_byte_clock_select_i = 1'b1;
    wr(CT, 8'h00);
    @(negedge mclk_i);
    sfr_req_i.addr = CL;
    repeat (2) @(negedge mclk_i);
    rv = sfr_rdata_o;
    repeat (30) @(negedge mclk_i);
    chk("stopped", rv, sfr_rdata_o);
    wr(RL, 8'hf0);
    wr(RH, 8'h80);
    wr(CL, 8'hf0);
    wr(CH, 8'hff);
    timer_irq_enable_i = 1'b1;
    wr(CT, 8'h04);
    wirq(1'b1);
    m = 32'hfff0;
    repeat (16) m = mdl_step(m, 32'h80f0, 16);
    rc("count_high", CH, 8'(m >> 8));
    rc("control", CT, 8'hc4);
    wr(CT, 8'hc0);
    repeat (40) @(negedge mclk_i);
    chk("irq_held", 8'h01, {7'h0, timer_irq_o});
    timer_irq_enable_i = 1'b0;
    wirq(1'b0);
    timer_irq_enable_i = 1'b1;
    wirq(1'b1);
    wr(CT, 8'h00);
    wirq(1'b0);
    rc("control", CT, 8'h00);
    wr(RL, 8'hfe);
    wr(RH, 8'h77);
    wr(CL, 8'hfe);
    wr(CH, 8'hff);
    wr(CT, 8'h08);
    repeat (10) @(negedge mclk_i);
    chk("irq_masked", 8'h00, {7'h0, timer_irq_o});
    rc("count_high", CH, 8'hff);
    rc("control", CT, 8'h48);
    wr(CT, 8'h28);
    wirq(1'b1);
    rc("control", CT, 8'h68);
    wr(CT, 8'h08);
    wirq(1'b0);
    wr(CT, 8'h0c);
    wirq(1'b1);
    rc("count_high", CH, 8'(mdl_step(32'hff, 32'h77, 8)));
    rc("control", CT, 8'hcc);
    high_byte_clock_select_i = 1'b1;
    gap(CH, g);
    chk("hi_gap", 8'h01, 8'(g));
    summarize();
  end
endmodule
